// ===== verilog/nvm_register_access_controller.sv
// Register front end of the nonvolatile memory controller
//
// Added by the designer: register access over Avalon-MM and the register addresses.
module nvm_register_access_controller
  import nvm_pkg::*;
#(
  parameter int FLASH_AW = 15
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [15:0] ind_addr,
  input wire logic ind_rd,
  input wire logic ind_wr,
  output logic [7:0] ind_data,
  output logic ind_valid,
  output logic core_stall,
  input wire logic protect_flash,
  input wire logic protect_uid,
  input wire logic protect_eeprom,
  output logic completion_irq
);
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
    logic [14:0] adr;
    logic [13:0] dat;
    logic rd;
    logic wr;
    logic write_enable_bit;
    logic free;
    logic lwlo;
    logic space;
    logic flag;
    logic ie;
    logic irq;
    op_e op;
    cmd_e cur;
    cmd_e cmd;
    logic ee_run;
    logic stall;
    logic ind_valid;
    logic [7:0] ind_data;
    logic [2:0] wp1;
    logic [2:0] wp2;
  } main_s;
  main_s s;
  main_s next_s;
  logic [1:0] rst_pipe;
  logic rst_n;
  logic [2:0] wp_pins;
  logic [7:0] wdat;
  logic wr_commit;
  logic ctl_wr;
  logic key_wr;
  logic other_wr;
  logic busy;
  logic armed;
  logic prot_hit;
  logic wr_try;
  cmd_e op_pick;
  nvm_array_if arr_bus();

  // Register read mux; key and unmapped offsets read zero
  function automatic logic [31:0] reg_read(input logic [4:0] a, input main_s st);
    if (a == ADR_LO_OFS)
      return {24'h000000, st.adr[7:0]};
    else if (a == ADR_HI_OFS)
      return {25'h0, st.adr[14:8]};
    else if (a == DAT_LO_OFS)
      return {24'h000000, st.dat[7:0]};
    else if (a == DAT_HI_OFS)
      return {26'h0, st.dat[13:8]};
    else if (a == CTL_OFS)
      return {25'h0, st.space, st.lwlo, st.free, 1'b0, st.write_enable_bit, st.wr, st.rd};
    else if (a == STAT_OFS)
      return {30'h0, st.ie, st.flag};
    return 32'h00000000;
  endfunction

  // Operation chosen by a write start; there is no bulk erase choice
  function automatic cmd_e pick(input logic sp, input logic fr, input logic lw,
                                input logic [14:0] a);
    if (sp && is_ee(a))
      return CMD_EEWR;
    if (fr)
      return CMD_ERASE;
    if (lw)
      return CMD_LOAD;
    return CMD_COMMIT;
  endfunction

  // Protection per target; read-only config space is always refused
  function automatic logic blocked(input logic sp, input logic [14:0] a,
                                   input logic [2:0] wp);
    if (!sp)
      return wp[WP_FLASH];
    if (is_ee(a))
      return wp[WP_EE];
    return wp[WP_UID] || (a >= 15'(UID_WORDS));
  endfunction

  // Reset release through two flops; first flop feeds only the second
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rst_pipe <= 2'b00;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];

  // Bus write decode; a write lands on the edge that sees waitrequest low
  assign wp_pins = {protect_eeprom, protect_uid, protect_flash};
  assign wdat = writedata[7:0];
  assign wr_commit = write && !s.waitrequest && byteenable[0];
  assign ctl_wr = wr_commit && (address == CTL_OFS);
  assign key_wr = wr_commit && (address == KEY_OFS);
  assign other_wr = wr_commit && (address != KEY_OFS);
  assign busy = (s.op == OP_READ) || (s.op == OP_RUN && !s.ee_run);
  assign op_pick = pick(wdat[CTL_SPACE], wdat[CTL_FREE], wdat[CTL_LWLO], s.adr);
  assign prot_hit = blocked(wdat[CTL_SPACE], s.adr, s.wp2);
  assign wr_try = ctl_wr && wdat[CTL_WR] && !wdat[CTL_RD] && (s.op == OP_IDLE);

  nvm_unlock u_unlock (
    .mclk(mclk),
    .rst_n(rst_n),
    .key_wr(key_wr),
    .key_val(wdat),
    .other_wr(other_wr),
    .armed(armed)
  );

  nvm_array #(.FLASH_AW(FLASH_AW)) u_array (
    .mclk(mclk),
    .rst_n(rst_n),
    .bus(arr_bus.array)
  );

  assign arr_bus.cmd = s.cmd;
  assign arr_bus.space = s.space;
  assign arr_bus.addr = s.adr;
  assign arr_bus.wdata = s.dat;
  assign arr_bus.ind_addr = ind_addr;

  // Next-state logic for bus, registers and operations
  always_comb
  begin
    next_s = s;
    next_s.cmd = CMD_NONE;
    next_s.waitrequest = 1'b1;
    next_s.wp1 = wp_pins;
    next_s.wp2 = s.wp1;
    // Indirect read: one stalled cycle, then the byte; writes ignored
    next_s.stall = ind_rd;
    next_s.ind_valid = s.stall;
    if (s.stall)
      next_s.ind_data = arr_bus.ind_data;
    // Accept a request unless the core must stay suspended
    if ((read || write) && s.waitrequest && !busy)
    begin
      next_s.waitrequest = 1'b0;
      next_s.readdata = reg_read(address, s);
    end
    if (wr_commit)
    begin
      if (address == ADR_LO_OFS)
        next_s.adr[7:0] = wdat;
      else if (address == ADR_HI_OFS)
        next_s.adr[14:8] = wdat[6:0];
      else if (address == DAT_LO_OFS)
        next_s.dat[7:0] = wdat;
      else if (address == DAT_HI_OFS)
        next_s.dat[13:8] = wdat[5:0];
      else if (address == STAT_OFS)
      begin
        if (wdat[STAT_FLAG])
          next_s.flag = 1'b0;
        next_s.ie = wdat[STAT_IE];
      end
      else if (address == CTL_OFS)
      begin
        next_s.write_enable_bit = wdat[CTL_WRITE_ENABLE_BIT];
        next_s.free = wdat[CTL_FREE];
        next_s.lwlo = wdat[CTL_LWLO];
        next_s.space = wdat[CTL_SPACE];
        // Clearing the start bits by software is never honoured
        if (wdat[CTL_RD] && s.op == OP_IDLE)
        begin
          next_s.rd = 1'b1;
          next_s.op = OP_READ;
          next_s.cmd = CMD_READ;
        end
      end
    end
    // Write start needs the armed key sequence and write enable
    if (wr_try && armed && s.write_enable_bit && !prot_hit)
    begin
      next_s.wr = 1'b1;
      next_s.op = OP_RUN;
      next_s.cur = op_pick;
      next_s.cmd = op_pick;
      next_s.ee_run = (op_pick == CMD_EEWR);
    end
    // Protected target leaves the start bit clear and nothing runs
    if (wr_try && prot_hit)
      next_s.wr = 1'b0;
    // Completion of the array operation
    if (arr_bus.done && s.op == OP_READ)
    begin
      next_s.dat = arr_bus.rdata;
      next_s.rd = 1'b0;
      next_s.op = OP_IDLE;
    end
    if (arr_bus.done && s.op == OP_RUN)
    begin
      next_s.wr = 1'b0;
      next_s.ee_run = 1'b0;
      next_s.op = OP_IDLE;
      // Latch loads are not reported; flag set beats a same-cycle clear
      if (s.cur != CMD_LOAD)
        next_s.flag = 1'b1;
    end
    next_s.irq = next_s.flag && next_s.ie;
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.waitrequest <= WAITREQ_RESET;
    end
    else
      s <= next_s;
  end

  assign readdata = s.readdata;
  assign waitrequest = s.waitrequest;
  assign ind_data = s.ind_data;
  assign ind_valid = s.ind_valid;
  assign core_stall = s.stall;
  assign completion_irq = s.irq;

  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_read_start;
    s.op == OP_READ && $past(s.op) != OP_READ;
  endsequence

  sequence s_read_end;
    s.op == OP_IDLE && !s.rd;
  endsequence

  property p_read_done;
    s_read_start |-> ##2 s_read_end;
  endproperty
  a_read_done: assert property (p_read_done) else $error("read start not cleared");

  property p_read_stall;
    s_read_start |-> s.waitrequest [*2];
  endproperty
  a_read_stall: assert property (p_read_stall) else $error("bus ran during read");

  property p_unlock_gate;
    $rose(s.wr) |-> $past(armed && s.write_enable_bit && ctl_wr);
  endproperty
  a_unlock_gate: assert property (p_unlock_gate) else $error("write without unlock");

  property p_prot;
    (wr_try && prot_hit) |=> !s.wr && s.op == OP_IDLE;
  endproperty
  a_prot: assert property (p_prot) else $error("protected target started");

  property p_no_write_enable_bit;
    (wr_try && !s.write_enable_bit) |=> !s.wr;
  endproperty
  a_no_write_enable_bit: assert property (p_no_write_enable_bit) else $error("start without write enable");

  property p_write_enable_bit_kept;
    (arr_bus.done && s.op == OP_RUN && !ctl_wr) |=> s.write_enable_bit == $past(s.write_enable_bit);
  endproperty
  a_write_enable_bit_kept: assert property (p_write_enable_bit_kept) else $error("write enable changed");

  property p_ee_held;
    s.ee_run |-> s.wr && s.op == OP_RUN;
  endproperty
  a_ee_held: assert property (p_ee_held) else $error("eeprom start bit lost");

  property p_ee_finish;
    (arr_bus.done && s.ee_run) |=> s.flag && !s.wr && !s.ee_run;
  endproperty
  a_ee_finish: assert property (p_ee_finish) else $error("eeprom end not flagged");

  property p_flash_stall;
    (s.op == OP_RUN && !s.ee_run) |-> s.waitrequest;
  endproperty
  a_flash_stall: assert property (p_flash_stall) else $error("core ran during flash op");

  property p_ind_read;
    ind_rd |=> s.stall ##1 s.ind_valid;
  endproperty
  a_ind_read: assert property (p_ind_read) else $error("indirect read timing");

  property p_ind_no_write;
    (ind_wr && !wr_commit && s.op == OP_IDLE) |=> s.op == OP_IDLE;
  endproperty
  a_ind_no_write: assert property (p_ind_no_write) else $error("indirect write acted");
endmodule // nvm_register_access_controller

// ===== verilog/nvm_pkg.sv
// Shared constants and types for the nonvolatile memory controller
package nvm_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] ADR_LO_OFS = 5'h00;
  localparam logic [4:0] ADR_HI_OFS = 5'h04;
  localparam logic [4:0] DAT_LO_OFS = 5'h08;
  localparam logic [4:0] DAT_HI_OFS = 5'h0c;
  localparam logic [4:0] CTL_OFS = 5'h10;
  localparam logic [4:0] KEY_OFS = 5'h14;
  localparam logic [4:0] STAT_OFS = 5'h18;
  // Control and status field positions
  localparam int CTL_RD = 0;
  localparam int CTL_WR = 1;
  localparam int CTL_WRITE_ENABLE_BIT = 2;
  localparam int CTL_FREE = 4;
  localparam int CTL_LWLO = 5;
  localparam int CTL_SPACE = 6;
  localparam int STAT_FLAG = 0;
  localparam int STAT_IE = 1;
  // Write-protect pin order
  localparam int WP_FLASH = 0;
  localparam int WP_UID = 1;
  localparam int WP_EE = 2;
  localparam logic WAITREQ_RESET = 1'b1;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
  localparam logic [14:0] EE_BASE = 15'h7000;
  localparam logic [7:0] IND_EE_PAGE = 8'h70;
  localparam int ROW_WORDS = 32;
  localparam int UID_WORDS = 4;
  localparam int EE_BYTES = 256;
  localparam logic [15:0] LATCH_RESET = 16'h7fff;
  // Self-timed operation lengths
  localparam int CLK_KHZ = 10000;
  localparam int ERASE_TIME_US = 2;
  localparam int PROG_TIME_US = 2;
  localparam int EE_TIME_US = 4;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_KHZ / 1000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_KHZ / 1000;
  localparam int EE_CYCLES = EE_TIME_US * CLK_KHZ / 1000;
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000, CMD_READ = 3'b001, CMD_LOAD = 3'b011,
    CMD_COMMIT = 3'b010, CMD_ERASE = 3'b110, CMD_EEWR = 3'b111
  } cmd_e;
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00, OP_READ = 2'b01, OP_RUN = 2'b11
  } op_e;
  typedef enum logic [1:0] {
    UL_IDLE = 2'b00, UL_KEY1 = 2'b01, UL_ARMED = 2'b11
  } unlock_e;
  // True for an address inside the EEPROM window
  function automatic logic is_ee(input logic [14:0] a);
    return a[14:8] == EE_BASE[14:8];
  endfunction
endpackage

// ===== verilog/nvm_array_if.sv
// Command and read channel between the controller and the memory arrays
interface nvm_array_if;
  import nvm_pkg::*;
  cmd_e cmd;
  logic space;
  logic [14:0] addr;
  logic [13:0] wdata;
  logic [13:0] rdata;
  logic done;
  logic [15:0] ind_addr;
  logic [7:0] ind_data;
  modport ctrl (output cmd, space, addr, wdata, ind_addr, input rdata, done, ind_data);
  modport array (input cmd, space, addr, wdata, ind_addr, output rdata, done, ind_data);
endinterface

// ===== verilog/nvm_unlock.sv
// Key sequence tracker that arms a single write start
module nvm_unlock
  import nvm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic key_wr,
  input wire logic [7:0] key_val,
  input wire logic other_wr,
  output logic armed
);
  typedef struct packed {
    unlock_e st;
  } ul_s;
  ul_s s;
  ul_s next_s;

  // Any write off the expected path drops back to idle
  always_comb
  begin
    next_s = s;
    if (key_wr && key_val == UNLOCK_KEY1)
      next_s.st = UL_KEY1;
    else if (key_wr && key_val == UNLOCK_KEY2 && s.st == UL_KEY1)
      next_s.st = UL_ARMED;
    else if (key_wr || other_wr)
      next_s.st = UL_IDLE;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign armed = (s.st == UL_ARMED);

  property p_arm_order;
    @(posedge mclk) disable iff (!rst_n)
    $rose(armed) |-> $past(key_wr && key_val == UNLOCK_KEY2 && s.st == UL_KEY1);
  endproperty
  a_arm_order: assert property (p_arm_order) else $error("armed without key order");

  property p_break;
    @(posedge mclk) disable iff (!rst_n)
    (other_wr && !key_wr) |=> !armed;
  endproperty
  a_break: assert property (p_break) else $error("stray write kept unlock");
endmodule // nvm_unlock

// ===== verilog/nvm_array.sv
// Flash, user ID, EEPROM arrays and the flash write latches
module nvm_array
  import nvm_pkg::*;
#(
  parameter int FLASH_AW = 15
)
(
  input wire logic mclk,
  input wire logic rst_n,
  nvm_array_if.array bus
);
  typedef struct packed {
    cmd_e cmd;
    logic [15:0] cnt;
    logic space;
    logic [14:0] addr;
    logic [13:0] wdata;
    logic [13:0] rdata;
    logic [7:0] ind_data;
    logic done;
  } arr_s;
  arr_s s;
  arr_s next_s;
  logic [13:0] flash [2**FLASH_AW];
  logic [13:0] uid [UID_WORDS];
  logic [7:0] ee [EE_BYTES];
  logic [13:0] latch [ROW_WORDS];
  logic finish;
  logic latch_clear;

  // Word view of either space; unmapped locations read as erased
  function automatic logic [13:0] word_at(input logic sp, input logic [14:0] a);
    if (!sp)
      return flash[a[FLASH_AW-1:0]];
    if (is_ee(a))
      return {6'h00, ee[a[7:0]]};
    if (a < 15'(UID_WORDS))
      return uid[a[$clog2(UID_WORDS)-1:0]];
    return 14'h3fff;
  endfunction

  assign finish = (s.cmd != CMD_NONE) && (s.cnt == 16'h0000);

  // Reads and latch loads answer next cycle, the rest run a timer
  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    if (finish)
    begin
      next_s.cmd = CMD_NONE;
      next_s.done = 1'b1;
    end
    else if (s.cmd != CMD_NONE)
      next_s.cnt = s.cnt - 16'h0001;
    else if (bus.cmd == CMD_READ || bus.cmd == CMD_LOAD)
    begin
      next_s.rdata = word_at(bus.space, bus.addr);
      next_s.done = 1'b1;
    end
    else if (bus.cmd != CMD_NONE)
    begin
      next_s.cmd = bus.cmd;
      next_s.space = bus.space;
      next_s.addr = bus.addr;
      next_s.wdata = bus.wdata;
      if (bus.cmd == CMD_ERASE)
        next_s.cnt = 16'(ERASE_CYCLES - 1);
      else if (bus.cmd == CMD_EEWR)
        next_s.cnt = 16'(EE_CYCLES - 1);
      else
        next_s.cnt = 16'(PROG_CYCLES - 1);
    end
    // Indirect path returns one byte per read
    if (bus.ind_addr[15])
      next_s.ind_data = flash[bus.ind_addr[FLASH_AW-1:0]][7:0];
    else if (bus.ind_addr[15:8] == IND_EE_PAGE)
      next_s.ind_data = ee[bus.ind_addr[7:0]];
    else
      next_s.ind_data = 8'h00;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  // Cells change only when a timed operation ends; no bulk erase exists
  always_ff @(posedge mclk)
  begin
    if (finish)
    begin
      case (s.cmd)
        CMD_ERASE:
        begin
          for (int i = 0; i < ROW_WORDS; i++)
            if (!s.space)
              flash[{s.addr[FLASH_AW-1:5], 5'(i)}] <= '1;
          for (int i = 0; i < UID_WORDS; i++)
            if (s.space)
              uid[i] <= '1;
        end
        CMD_COMMIT:
        begin
          // Programming only pulls bits low, never erases first
          for (int i = 0; i < ROW_WORDS; i++)
            if (!s.space)
              flash[{s.addr[FLASH_AW-1:5], 5'(i)}] <=
                flash[{s.addr[FLASH_AW-1:5], 5'(i)}] & latch[i];
          for (int i = 0; i < UID_WORDS; i++)
            if (s.space)
              uid[i] <= uid[i] & latch[i];
        end
        CMD_EEWR: ee[s.addr[7:0]] <= s.wdata[7:0];
        default: ;
      endcase
    end
  end

  // Latches load by low address bits and return to erased after a commit
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      for (int i = 0; i < ROW_WORDS; i++)
        latch[i] <= LATCH_RESET[13:0];
    else if (finish && s.cmd == CMD_COMMIT)
      for (int i = 0; i < ROW_WORDS; i++)
        latch[i] <= LATCH_RESET[13:0];
    else if (bus.cmd == CMD_LOAD && s.cmd == CMD_NONE)
      latch[bus.addr[4:0]] <= bus.wdata;
  end

  // True while every latch holds the erased pattern; checks the whole row
  always_comb
  begin
    latch_clear = 1'b1;
    for (int i = 0; i < ROW_WORDS; i++)
      if (latch[i] != LATCH_RESET[13:0])
        latch_clear = 1'b0;
  end

  assign bus.rdata = s.rdata;
  assign bus.done = s.done;
  assign bus.ind_data = s.ind_data;

  property p_latch_reset;
    @(posedge mclk) disable iff (!rst_n)
    (finish && s.cmd == CMD_COMMIT) |=> latch_clear;
  endproperty
  a_latch_reset: assert property (p_latch_reset) else $error("latch not reset");

  property p_erase_keeps_latch;
    @(posedge mclk) disable iff (!rst_n)
    (finish && s.cmd == CMD_ERASE) |=> latch[0] == $past(latch[0]);
  endproperty
  a_erase_keeps_latch: assert property (p_erase_keeps_latch) else $error("erase hit latch");
endmodule // nvm_array

// ===== dv/nvm_core_model.sv
// Processor core model: Avalon-MM master issuing register cycles
module nvm_core_model
  import nvm_pkg::*;
(
  input wire logic mclk,
  output logic [4:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  output logic hung
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero; only byte lane 0 carries register data
  initial
  begin
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h1;
    hung = 1'b0;
  end

  // One bus cycle; an edge passes first so strobes never change twice per step
  task automatic xfer(input logic rw, input logic [4:0] a, input logic [7:0] d,
                      input logic [3:0] be, output logic [7:0] q);
    int n;
    @(posedge mclk);
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    write <= rw;
    read <= !rw;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 500);
    if (n >= 500)
      hung = 1'b1;
    q = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
  endtask

  // Keys then start, with nothing in between; the interrupt enable is left as it stands
  task automatic unlock(input logic [7:0] ctl);
    logic [7:0] q;
    xfer(1'b1, KEY_OFS, UNLOCK_KEY1, 4'h1, q);
    xfer(1'b1, KEY_OFS, UNLOCK_KEY2, 4'h1, q);
    xfer(1'b1, CTL_OFS, ctl | 8'h02, 4'h1, q);
  endtask
endmodule // nvm_core_model

// ===== dv/nvm_register_access_controller_tb_top.sv
// Self-checking bench for the nonvolatile memory controller
module nvm_register_access_controller_tb_top
  import nvm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk;
  logic resetn;
  logic [4:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  logic [15:0] ind_addr;
  logic ind_rd;
  logic ind_wr;
  logic [7:0] ind_data;
  logic ind_valid;
  logic core_stall;
  logic protect_flash;
  logic protect_uid;
  logic protect_eeprom;
  logic completion_irq;
  logic hung;
  int error_cnt = 0;
  int cmp_count = 0;

  // Small flash keeps the array model light
  nvm_register_access_controller #(.FLASH_AW(8)) nvm_register_access_controller_i (
    .mclk(mclk), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .ind_addr(ind_addr), .ind_rd(ind_rd), .ind_wr(ind_wr),
    .ind_data(ind_data), .ind_valid(ind_valid), .core_stall(core_stall),
    .protect_flash(protect_flash), .protect_uid(protect_uid),
    .protect_eeprom(protect_eeprom), .completion_irq(completion_irq));

  nvm_core_model nvm_core_model_i (
    .mclk(mclk), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .hung(hung));

  // 10 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    nvm_core_model_i.xfer(1'b1, a, d, 4'h1, q);
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] q);
    nvm_core_model_i.xfer(1'b0, a, 8'h00, 4'h1, q);
  endtask

  // Space is chosen before the address is loaded
  task automatic op(input logic [7:0] ctl, input logic [14:0] a);
    wr(CTL_OFS, ctl);
    wr(ADR_LO_OFS, a[7:0]);
    wr(ADR_HI_OFS, {1'b0, a[14:8]});
  endtask

  task automatic read_word(input logic sp, input logic [14:0] a, output logic [15:0] w);
    logic [7:0] lo;
    logic [7:0] hi;
    op({1'b0, sp, 6'h00}, a);
    wr(CTL_OFS, {1'b0, sp, 6'h01});
    rd(DAT_LO_OFS, lo);
    rd(DAT_HI_OFS, hi);
    w = {2'b00, hi[5:0], lo};
  endtask

  task automatic load(input logic [14:0] a, input logic [13:0] d);
    op(8'h24, a);
    wr(DAT_LO_OFS, d[7:0]);
    wr(DAT_HI_OFS, {2'b00, d[13:8]});
    nvm_core_model_i.unlock(8'h24);
  endtask

  // Indirect read: stall one cycle after the pulse, byte the cycle after
  task automatic ind_read(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk);
    ind_addr <= a;
    ind_rd <= 1'b1;
    @(posedge mclk);
    ind_rd <= 1'b0;
    @(posedge mclk);
    chk("core_stall", 16'h1, {15'h0, core_stall});
    @(posedge mclk);
    chk("ind_valid", 16'h1, {15'h0, ind_valid});
    chk("ind_data", {8'h00, exp}, {8'h00, ind_data});
  endtask

  task automatic t_reset;
    logic [7:0] q;
    rd(CTL_OFS, q);
    chk("ctl", 16'h0, {8'h00, q});
    rd(STAT_OFS, q);
    chk("stat", 16'h0, {8'h00, q});
    chk("irq", 16'h0, {15'h0, completion_irq});
    $display("test reset done");
  endtask

  // Erase, load, commit twice: programming only clears bits
  task automatic t_flash;
    logic [7:0] q;
    logic [15:0] w;
    op(8'h14, 15'h0020);
    nvm_core_model_i.unlock(8'h14);
    rd(CTL_OFS, q);
    chk("ctl after erase", 16'h0014, {8'h00, q});
    rd(STAT_OFS, q);
    chk("flag after erase", 16'h0001, {8'h00, q});
    wr(STAT_OFS, 8'h01);
    read_word(1'b0, 15'h0023, w);
    chk("erased word", 16'h3fff, w);
    rd(CTL_OFS, q);
    chk("rd cleared", 16'h0, {8'h00, q});
    load(15'h0023, 14'h1234);
    op(8'h04, 15'h0020);
    nvm_core_model_i.unlock(8'h04);
    read_word(1'b0, 15'h0023, w);
    chk("programmed word", 16'h1234, w);
    read_word(1'b0, 15'h0021, w);
    chk("untouched word", 16'h3fff, w);
    load(15'h0023, 14'h0ff0);
    op(8'h04, 15'h0020);
    nvm_core_model_i.unlock(8'h04);
    read_word(1'b0, 15'h0023, w);
    chk("reprogrammed word", 16'h0230, w);
    $display("test flash done");
  endtask

  // Protected, broken and disabled erases must leave the row alone
  task automatic t_block;
    logic [7:0] q;
    logic [15:0] w;
    protect_flash <= 1'b1;
    wr(STAT_OFS, 8'h01);
    op(8'h14, 15'h0020);
    nvm_core_model_i.unlock(8'h14);
    rd(CTL_OFS, q);
    chk("ctl protected", 16'h0014, {8'h00, q});
    protect_flash <= 1'b0;
    wr(KEY_OFS, UNLOCK_KEY1);
    wr(DAT_LO_OFS, 8'h00);
    wr(KEY_OFS, UNLOCK_KEY2);
    wr(CTL_OFS, 8'h16);
    op(8'h10, 15'h0020);
    nvm_core_model_i.unlock(8'h10);
    rd(STAT_OFS, q);
    chk("no flag", 16'h0, {8'h00, q});
    read_word(1'b0, 15'h0023, w);
    chk("row kept", 16'h0230, w);
    ind_read(16'h8023, 8'h30);
    $display("test block done");
  endtask

  // Byte write runs beside the core; software cannot cut it short
  task automatic t_eeprom;
    logic [7:0] q;
    logic [15:0] w;
    int n;
    wr(STAT_OFS, 8'h03);
    op(8'h44, 15'h7005);
    wr(DAT_LO_OFS, 8'ha5);
    nvm_core_model_i.unlock(8'h44);
    rd(CTL_OFS, q);
    chk("wr running", 16'h0046, {8'h00, q});
    wr(CTL_OFS, 8'h44);
    rd(CTL_OFS, q);
    chk("wr kept", 16'h0046, {8'h00, q});
    n = 0;
    do
    begin
      rd(CTL_OFS, q);
      n++;
    end
    while (q[1] !== 1'b0 && n < 100);
    chk("ctl done", 16'h0044, {8'h00, q});
    chk("irq", 16'h1, {15'h0, completion_irq});
    read_word(1'b1, 15'h7005, w);
    chk("ee byte", 16'h00a5, w);
    @(posedge mclk);
    ind_addr <= 16'h7005;
    ind_wr <= 1'b1;
    @(posedge mclk);
    ind_wr <= 1'b0;
    ind_read(16'h7005, 8'ha5);
    protect_eeprom <= 1'b1;
    op(8'h44, 15'h7005);
    wr(DAT_LO_OFS, 8'h5a);
    nvm_core_model_i.unlock(8'h44);
    read_word(1'b1, 15'h7005, w);
    chk("ee protected", 16'h00a5, w);
    wr(STAT_OFS, 8'h01);
    rd(STAT_OFS, q);
    chk("irq cleared", 16'h0, {15'h0, completion_irq});
    $display("test eeprom done");
  endtask

  // User ID row: protected erase refused, then erased; config area reads erased
  task automatic t_uid;
    logic [7:0] q;
    logic [15:0] w;
    protect_uid <= 1'b1;
    op(8'h54, 15'h0001);
    nvm_core_model_i.unlock(8'h54);
    rd(CTL_OFS, q);
    chk("uid protected", 16'h0054, {8'h00, q});
    protect_uid <= 1'b0;
    nvm_core_model_i.unlock(8'h54);
    rd(STAT_OFS, q);
    chk("uid erase flag", 16'h0001, {8'h00, q});
    read_word(1'b1, 15'h0001, w);
    chk("uid erased", 16'h3fff, w);
    read_word(1'b1, 15'h0007, w);
    chk("config word", 16'h3fff, w);
    nvm_core_model_i.xfer(1'b1, DAT_LO_OFS, 8'h00, 4'h0, q);
    rd(DAT_LO_OFS, q);
    chk("lane off write", 16'h00ff, {8'h00, q});
    $display("test uid done");
  endtask

  task automatic results;
    if (hung === 1'b1)
      error_cnt++;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    resetn = 1'b0;
    ind_addr = 16'h0000;
    ind_rd = 1'b0;
    ind_wr = 1'b0;
    protect_flash = 1'b0;
    protect_uid = 1'b0;
    protect_eeprom = 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_flash();
    t_block();
    t_eeprom();
    t_uid();
    results();
  end

  // Watchdog well beyond the several hundred cycles the tests need
  initial
  begin
    #3000000;
    error_cnt++;
    results();
  end
endmodule // nvm_register_access_controller_tb_top
